//--- rtl/cal_word_reg.v
// Purpose: Calibration word with range or exponent check and write lockout
// Assumes: Write strobe is one cycle on CORE_CLK
// Notes: Rejected writes leave the word unchanged
`timescale 1ns/1ps
`include "pmbus_status_cal_regs.vh"
`default_nettype none
module cal_word_reg #(
  parameter [15:0] RESET = `GAIN_RESET,
  parameter CHECK_EXP = 0,
  parameter [4:0] EXP = `VOUT_OFFSET_EXP,
  parameter [15:0] MIN = `GAIN_MIN,
  parameter [15:0] MAX = `GAIN_MAX
) (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [15:0] wr_data,
  input wire protect,
  output reg [15:0] q,
  output wire reject
);
  wire bad_value;

  assign bad_value = (CHECK_EXP != 0) ? (wr_data[`LIN_EXP_MSB:`LIN_EXP_LSB] != EXP)
                                      : ((wr_data < MIN) || (wr_data > MAX));
  assign reject = wr_en && (bad_value || protect);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET;
    end else if (wr_en && !reject) begin
      q <= wr_data;
    end
  end
endmodule // cal_word_reg
`default_nettype wire

//--- rtl/pmbus_status_cal_bank.v
// Purpose: Status, telemetry, identity and calibration command bank of the management interface
// Assumes: A transaction engine on CORE_CLK presents decoded command code, strobes and data
// Notes: Fault conditions arrive from the power stage and are synchronised here
`timescale 1ns/1ps
`include "pmbus_status_cal_regs.vh"
`default_nettype none
module pmbus_status_cal_bank #(
  parameter [5:0] MODULE_NAME = 6'h21  // Arbitrary designation, top bit set
) (
  input wire CORE_CLK,
  input wire NRST,
  // Command port
  input wire [7:0] CMD_CODE,
  input wire WR_STB,
  input wire [15:0] WR_DATA,
  input wire RD_STB,
  input wire PEC_ERR,
  output reg [15:0] RD_DATA,
  output reg RD_VALID,
  output reg WR_DONE,
  output reg WR_REJECT,
  // Fault conditions from the power stage
  input wire VOUT_OV_IN,
  input wire OVERCURRENT_FAULT_IN,
  input wire OVERCURRENT_WARNING_IN,
  input wire VIN_OV_IN,
  input wire VIN_UV_IN,
  input wire UNIT_OFF_LOW_VIN_IN,
  input wire OVERTEMPERATURE_FAULT_IN,
  input wire OVERTEMPERATURE_WARNING_IN,
  // Telemetry from the conversion logic
  input wire [15:0] VIN_MEAS,
  input wire [15:0] VOUT_MEAS,
  input wire [15:0] IOUT_MEAS,
  input wire [15:0] TEMP_MEAS,
  // Stored factors and state
  output reg [15:0] VOUT_GAIN,
  output reg [15:0] VOUT_OFFSET,
  output reg [15:0] VIN_GAIN,
  output reg WRITE_PROTECT,
  output reg [7:0] SUMMARY_LOW
);
  localparam NUM_FAULTS = 8;
  // Positions of the fault levels in the synchroniser
  localparam FLT_VOUT_OV = 0;
  localparam FLT_IOUT_OC = 1;
  localparam FLT_IOUT_WARN = 2;
  localparam FLT_VIN_OV = 3;
  localparam FLT_VIN_UV = 4;
  localparam FLT_UNIT_OFF = 5;
  localparam FLT_TEMP_FAULT = 6;
  localparam FLT_TEMP_WARN = 7;

  // ============================================================
  // Command decode
  function is_known;
    input [7:0] code;
    begin
      case (code)
        `CMD_SUMMARY_STATUS, `CMD_VOUT_STATUS, `CMD_IOUT_STATUS, `CMD_INPUT_STATUS,
        `CMD_TEMP_STATUS, `CMD_COMM_STATUS, `CMD_MEAS_VIN, `CMD_MEAS_VOUT,
        `CMD_MEAS_IOUT, `CMD_MEAS_TEMP, `CMD_IDENTITY, `CMD_VOUT_GAIN,
        `CMD_VOUT_OFFSET, `CMD_VIN_GAIN: is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  function is_read_only;
    input [7:0] code;
    begin
      case (code)
        `CMD_SUMMARY_STATUS, `CMD_MEAS_VIN, `CMD_MEAS_VOUT,
        `CMD_MEAS_IOUT, `CMD_MEAS_TEMP: is_read_only = 1'b1;
        default: is_read_only = 1'b0;
      endcase
    end
  endfunction

  // ============================================================
  // Fault input synchronisers
  wire [NUM_FAULTS-1:0] fault_raw;
  reg [NUM_FAULTS-1:0] fault_meta_q;
  reg [NUM_FAULTS-1:0] fault_q;

  assign fault_raw = {OVERTEMPERATURE_WARNING_IN, OVERTEMPERATURE_FAULT_IN, UNIT_OFF_LOW_VIN_IN, VIN_UV_IN,
                      VIN_OV_IN, OVERCURRENT_WARNING_IN, OVERCURRENT_FAULT_IN, VOUT_OV_IN};

  genvar g;
  generate
    for (g = 0; g < NUM_FAULTS; g = g + 1) begin : g_sync
      always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          fault_meta_q[g] <= 1'b0;
          fault_q[g] <= 1'b0;
        end else begin
          fault_meta_q[g] <= fault_raw[g];
          fault_q[g] <= fault_meta_q[g];
        end
      end
    end
  endgenerate

  // ============================================================
  // Status bytes
  wire wr_known;
  wire wr_cmd_bad;
  reg [7:0] vout_set;
  reg [7:0] iout_set;
  reg [7:0] input_set;
  reg [7:0] temp_set;
  reg [7:0] comm_set;
  wire [7:0] vout_status;
  wire [7:0] iout_status;
  wire [7:0] input_status;
  wire [7:0] temp_status;
  wire [7:0] comm_status;
  wire cal_reject;

  assign wr_known = WR_STB && is_known(CMD_CODE) && !is_read_only(CMD_CODE);
  assign wr_cmd_bad = WR_STB && !wr_known;

  // ============================================================
  // Fault levels into set requests
  always @* begin
    vout_set = 8'h00;
    vout_set[`BIT_OUTPUT_OVERVOLTAGE_FAULT] = fault_q[FLT_VOUT_OV];
  end

  always @* begin
    iout_set = 8'h00;
    iout_set[`BIT_OVERCURRENT_FAULT] = fault_q[FLT_IOUT_OC];
    iout_set[`BIT_OVERCURRENT_WARNING] = fault_q[FLT_IOUT_WARN];
  end

  always @* begin
    input_set = 8'h00;
    input_set[`BIT_INPUT_OVERVOLTAGE_FAULT] = fault_q[FLT_VIN_OV];
    input_set[`BIT_INPUT_UNDERVOLTAGE_FAULT] = fault_q[FLT_VIN_UV];
    input_set[`BIT_UNIT_OFF_LOW_VIN] = fault_q[FLT_UNIT_OFF];
  end

  always @* begin
    temp_set = 8'h00;
    temp_set[`BIT_OVERTEMPERATURE_FAULT] = fault_q[FLT_TEMP_FAULT];
    temp_set[`BIT_OVERTEMPERATURE_WARNING] = fault_q[FLT_TEMP_WARN];
  end

  // Command faults for the communication byte
  always @* begin
    comm_set = 8'h00;
    comm_set[`BIT_INVALID_CMD] = wr_cmd_bad || (RD_STB && !is_known(CMD_CODE));
    comm_set[`BIT_INVALID_DATA] = cal_reject;
    comm_set[`BIT_PEC_FAILED] = PEC_ERR;
  end

  sticky_status_byte #(.MASK(`MASK_VOUT_STATUS)) u_vout_status (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .set(vout_set),
    .clr_en(WR_STB && (CMD_CODE == `CMD_VOUT_STATUS)),
    .clr(WR_DATA[7:0]),
    .q(vout_status)
  );

  sticky_status_byte #(.MASK(`MASK_IOUT_STATUS)) u_iout_status (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .set(iout_set),
    .clr_en(WR_STB && (CMD_CODE == `CMD_IOUT_STATUS)),
    .clr(WR_DATA[7:0]),
    .q(iout_status)
  );

  sticky_status_byte #(.MASK(`MASK_INPUT_STATUS)) u_input_status (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .set(input_set),
    .clr_en(WR_STB && (CMD_CODE == `CMD_INPUT_STATUS)),
    .clr(WR_DATA[7:0]),
    .q(input_status)
  );

  sticky_status_byte #(.MASK(`MASK_TEMP_STATUS)) u_temp_status (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .set(temp_set),
    .clr_en(WR_STB && (CMD_CODE == `CMD_TEMP_STATUS)),
    .clr(WR_DATA[7:0]),
    .q(temp_status)
  );

  sticky_status_byte #(.MASK(`MASK_COMM_STATUS)) u_comm_status (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .set(comm_set),
    .clr_en(WR_STB && (CMD_CODE == `CMD_COMM_STATUS)),
    .clr(WR_DATA[7:0]),
    .q(comm_status)
  );

  // ============================================================
  // Identity and write protect
  reg protect_q;
  reg [15:0] identity_word;

  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      protect_q <= `ID_PROTECT_RESET;
    end else if (WR_STB && (CMD_CODE == `CMD_IDENTITY)) begin
      protect_q <= WR_DATA[`ID_PROTECT_BIT];
    end
  end

  // Designation is fixed; its top bit is forced high
  always @* begin
    identity_word = 16'h0000;
    identity_word[`ID_NAME_LSB +: 6] = {1'b1, MODULE_NAME[4:0]};
    identity_word[`ID_PROTECT_BIT] = protect_q;
  end

  // ============================================================
  // Calibration words
  wire [15:0] vout_gain_w;
  wire [15:0] vout_offset_w;
  wire [15:0] vin_gain_w;
  wire rej_vout_gain;
  wire rej_vout_offset;
  wire rej_vin_gain;

  assign cal_reject = rej_vout_gain || rej_vout_offset || rej_vin_gain;

  cal_word_reg #(.RESET(`GAIN_RESET), .CHECK_EXP(0)) u_vout_gain (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .wr_en(WR_STB && (CMD_CODE == `CMD_VOUT_GAIN)),
    .wr_data(WR_DATA),
    .protect(protect_q),
    .q(vout_gain_w),
    .reject(rej_vout_gain)
  );

  cal_word_reg #(.RESET(`VOUT_OFFSET_RESET), .CHECK_EXP(1), .EXP(`VOUT_OFFSET_EXP)) u_vout_offset (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .wr_en(WR_STB && (CMD_CODE == `CMD_VOUT_OFFSET)),
    .wr_data(WR_DATA),
    .protect(protect_q),
    .q(vout_offset_w),
    .reject(rej_vout_offset)
  );

  cal_word_reg #(.RESET(`GAIN_RESET), .CHECK_EXP(0)) u_vin_gain (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .wr_en(WR_STB && (CMD_CODE == `CMD_VIN_GAIN)),
    .wr_data(WR_DATA),
    .protect(protect_q),
    .q(vin_gain_w),
    .reject(rej_vin_gain)
  );

  // ============================================================
  // Summary low byte
  reg [7:0] summary_d;

  always @* begin
    summary_d = 8'h00;
    summary_d[`SUM_UNIT_OFF] = input_status[`BIT_UNIT_OFF_LOW_VIN];
    summary_d[`SUM_VOUT_OV] = vout_status[`BIT_OUTPUT_OVERVOLTAGE_FAULT];
    summary_d[`SUM_IOUT_OC] = iout_status[`BIT_OVERCURRENT_FAULT];
    summary_d[`SUM_VIN_UV] = input_status[`BIT_INPUT_UNDERVOLTAGE_FAULT];
    summary_d[`SUM_TEMP] = |temp_status;
    summary_d[`SUM_COMM] = |comm_status;
  end

  // ============================================================
  // Read mux
  reg [15:0] rd_d;

  always @* begin
    case (CMD_CODE)
      `CMD_SUMMARY_STATUS: rd_d = {8'h00, summary_d};
      `CMD_VOUT_STATUS: rd_d = {8'h00, vout_status};
      `CMD_IOUT_STATUS: rd_d = {8'h00, iout_status};
      `CMD_INPUT_STATUS: rd_d = {8'h00, input_status};
      `CMD_TEMP_STATUS: rd_d = {8'h00, temp_status};
      `CMD_COMM_STATUS: rd_d = {8'h00, comm_status};
      `CMD_MEAS_VIN: rd_d = VIN_MEAS;
      `CMD_MEAS_VOUT: rd_d = VOUT_MEAS;
      `CMD_MEAS_IOUT: rd_d = IOUT_MEAS;
      `CMD_MEAS_TEMP: rd_d = TEMP_MEAS;
      `CMD_IDENTITY: rd_d = identity_word;
      `CMD_VOUT_GAIN: rd_d = vout_gain_w;
      `CMD_VOUT_OFFSET: rd_d = vout_offset_w;
      `CMD_VIN_GAIN: rd_d = vin_gain_w;
      default: rd_d = 16'h0000;
    endcase
  end

  // ============================================================
  // Registered outputs
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= 16'h0000;
      RD_VALID <= 1'b0;
      WR_DONE <= 1'b0;
      WR_REJECT <= 1'b0;
      VOUT_GAIN <= `GAIN_RESET;
      VOUT_OFFSET <= `VOUT_OFFSET_RESET;
      VIN_GAIN <= `GAIN_RESET;
      WRITE_PROTECT <= `ID_PROTECT_RESET;
      SUMMARY_LOW <= 8'h00;
    end else begin
      if (RD_STB) begin
        RD_DATA <= rd_d;
      end
      RD_VALID <= RD_STB;
      WR_DONE <= WR_STB && wr_known && !cal_reject;
      WR_REJECT <= wr_cmd_bad || cal_reject;
      // Stored copies follow the calibration words, protect bit and summary byte
      VOUT_GAIN <= vout_gain_w;
      VOUT_OFFSET <= vout_offset_w;
      VIN_GAIN <= vin_gain_w;
      WRITE_PROTECT <= protect_q;
      SUMMARY_LOW <= summary_d;
    end
  end
endmodule // pmbus_status_cal_bank
`default_nettype wire

//--- rtl/pmbus_status_cal_regs.vh
// Purpose: Command codes, field positions and reset values for the status and calibration bank
// Assumes: Included by the bank and by cal_word_reg
// Notes: Definitions only
`ifndef PMBUS_STATUS_CAL_REGS_VH
`define PMBUS_STATUS_CAL_REGS_VH

// ============================================================
// Command codes
`define CMD_SUMMARY_STATUS 8'h79
`define CMD_VOUT_STATUS 8'h7a
`define CMD_IOUT_STATUS 8'h7b
`define CMD_INPUT_STATUS 8'h7c
`define CMD_TEMP_STATUS 8'h7d
`define CMD_COMM_STATUS 8'h7e
`define CMD_MEAS_VIN 8'h88
`define CMD_MEAS_VOUT 8'h8b
`define CMD_MEAS_IOUT 8'h8c
`define CMD_MEAS_TEMP 8'h8d
`define CMD_IDENTITY 8'hd0
`define CMD_VOUT_GAIN 8'hd1
`define CMD_VOUT_OFFSET 8'hd2
`define CMD_VIN_GAIN 8'hd3

// ============================================================
// Status bit positions
`define BIT_OUTPUT_OVERVOLTAGE_FAULT 7
`define BIT_OVERCURRENT_FAULT 7
`define BIT_OVERCURRENT_WARNING 5
`define BIT_INPUT_OVERVOLTAGE_FAULT 7
`define BIT_INPUT_UNDERVOLTAGE_FAULT 4
`define BIT_UNIT_OFF_LOW_VIN 3
`define BIT_OVERTEMPERATURE_FAULT 7
`define BIT_OVERTEMPERATURE_WARNING 6
`define BIT_INVALID_CMD 7
`define BIT_INVALID_DATA 6
`define BIT_PEC_FAILED 5

// Supported-bit masks
`define MASK_VOUT_STATUS 8'h80
`define MASK_IOUT_STATUS 8'ha0
`define MASK_INPUT_STATUS 8'h98
`define MASK_TEMP_STATUS 8'hc0
`define MASK_COMM_STATUS 8'he0

// Summary low byte positions
`define SUM_UNIT_OFF 6
`define SUM_VOUT_OV 5
`define SUM_IOUT_OC 4
`define SUM_VIN_UV 3
`define SUM_TEMP 2
`define SUM_COMM 1

// ============================================================
// Identity and write protect
`define ID_PROTECT_BIT 1
`define ID_NAME_LSB 2
`define ID_PROTECT_RESET 1'b1

// ============================================================
// Calibration
`define GAIN_RESET 16'h2000
`define GAIN_MIN 16'h1999
`define GAIN_MAX 16'h2666
`define VOUT_OFFSET_EXP 5'h14
`define VOUT_OFFSET_RESET 16'ha000
`define LIN_EXP_MSB 15
`define LIN_EXP_LSB 11

`endif

//--- rtl/sticky_status_byte.v
// Purpose: One status byte with sticky flags cleared by writing ones
// Assumes: Set and clear arrive on CORE_CLK
// Notes: Unsupported bits stay zero through MASK
`timescale 1ns/1ps
`default_nettype none
module sticky_status_byte #(
  parameter [7:0] MASK = 8'hff
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] set,
  input wire clr_en,
  input wire [7:0] clr,
  output reg [7:0] q
);
  wire [7:0] keep;
  wire [7:0] flags_d;

  // A set in the same cycle as its clear survives
  assign keep = clr_en ? (q & ~clr) : q;
  assign flags_d = (keep | set) & MASK;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 8'h00;
    end else begin
      q <= flags_d;
    end
  end
endmodule // sticky_status_byte
`default_nettype wire

//--- test/pmbus_host_model.sv
// Purpose: Host controller model driving the command port
// Assumes: Strobes are single-cycle pulses answered one cycle later
// Notes: Released command and data lines show the inverse of their last value; strobes return low
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire CORE_CLK,
  input wire [15:0] RD_DATA,
  input wire RD_VALID,
  input wire WR_DONE,
  input wire WR_REJECT,
  output logic [7:0] CMD_CODE,
  output logic WR_STB,
  output logic [15:0] WR_DATA,
  output logic RD_STB,
  output logic PEC_ERR
);
  initial begin
    CMD_CODE = 8'h00;
    WR_STB = 1'b0;
    WR_DATA = 16'h0000;
    RD_STB = 1'b0;
    PEC_ERR = 1'b0;
  end
  // One transfer, then one idle edge before the next may start
  task xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data, output logic [15:0] got);
    @(posedge CORE_CLK);
    #1;
    CMD_CODE = cmd;
    WR_DATA = data;
    WR_STB = wr;
    RD_STB = !wr;
    @(posedge CORE_CLK);
    #1;
    got = wr ? {14'h0000, WR_DONE, WR_REJECT} : (RD_VALID ? RD_DATA : 16'hdead);
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    CMD_CODE = ~cmd;
    WR_DATA = ~data;
  endtask
  task pec_fail;
    @(posedge CORE_CLK);
    #1;
    PEC_ERR = 1'b1;
    @(posedge CORE_CLK);
    #1;
    PEC_ERR = 1'b0;
  endtask
endmodule // pmbus_host_model
`default_nettype wire

//--- test/pmbus_status_and_calibration_regs_bench.sv
// Purpose: Self-checking bench for the status and calibration bank
// Assumes: Host model drives the command port
// Notes: Write answers read as 2 for done and 1 for refused
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_and_calibration_regs_bench;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] flt = 8'h00;
  logic [15:0] VIN_MEAS = 16'h1234, VOUT_MEAS = 16'h0c1d, IOUT_MEAS = 16'h2344, TEMP_MEAS = 16'h0456;
  wire [7:0] CMD_CODE, SUMMARY_LOW;
  wire [15:0] WR_DATA, RD_DATA, VOUT_GAIN, VOUT_OFFSET, VIN_GAIN;
  wire WR_STB, RD_STB, PEC_ERR, RD_VALID, WR_DONE, WR_REJECT, WRITE_PROTECT;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] got;
  logic [7:0] scode [0:3] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d};
  logic [15:0] sexp [0:3] = '{16'h0080, 16'h00a0, 16'h0098, 16'h00c0};
  logic [40:0] rows [0:28] = '{
    {1'b0, 8'hd0, 16'h0000, 16'h0086}, {1'b0, 8'hd1, 16'h0000, 16'h2000},
    {1'b0, 8'hd3, 16'h0000, 16'h2000}, {1'b1, 8'hd3, 16'h2100, 16'h0001},
    {1'b0, 8'h7e, 16'h0000, 16'h0040}, {1'b1, 8'h7e, 16'h00ff, 16'h0002},
    {1'b1, 8'hd0, 16'h0000, 16'h0002}, {1'b1, 8'hd3, 16'h2100, 16'h0002},
    {1'b1, 8'hd1, 16'h1998, 16'h0001}, {1'b1, 8'hd1, 16'h2667, 16'h0001},
    {1'b1, 8'hd1, 16'h1999, 16'h0002}, {1'b1, 8'hd1, 16'h2666, 16'h0002},
    {1'b0, 8'hd1, 16'h0000, 16'h2666}, {1'b1, 8'hd2, 16'h9fff, 16'h0001},
    {1'b1, 8'hd2, 16'ha123, 16'h0002}, {1'b0, 8'hd2, 16'h0000, 16'ha123},
    {1'b0, 8'h7e, 16'h0000, 16'h0040}, {1'b1, 8'h7e, 16'h00ff, 16'h0002},
    {1'b1, 8'h55, 16'h0000, 16'h0001}, {1'b1, 8'h88, 16'h1234, 16'h0001},
    {1'b0, 8'h55, 16'h0000, 16'h0000}, {1'b0, 8'h7e, 16'h0000, 16'h0080},
    {1'b0, 8'h88, 16'h0000, 16'h1234}, {1'b0, 8'h8d, 16'h0000, 16'h0456},
    {1'b1, 8'hd0, 16'h0002, 16'h0002}, {1'b1, 8'hd3, 16'h2200, 16'h0001},
    {1'b0, 8'h79, 16'h0000, 16'h0002}, {1'b0, 8'h8b, 16'h0000, 16'h0c1d},
    {1'b0, 8'h8c, 16'h0000, 16'h2344}};

  always #2.5 CORE_CLK = ~CORE_CLK;

  pmbus_host_model host (.CORE_CLK, .RD_DATA, .RD_VALID, .WR_DONE, .WR_REJECT, .CMD_CODE, .WR_STB, .WR_DATA,
    .RD_STB, .PEC_ERR);
  pmbus_status_cal_bank uut (.CORE_CLK, .NRST, .CMD_CODE, .WR_STB, .WR_DATA, .RD_STB, .PEC_ERR, .RD_DATA,
    .RD_VALID, .WR_DONE, .WR_REJECT, .VOUT_OV_IN(flt[0]), .OVERCURRENT_FAULT_IN(flt[1]),
    .OVERCURRENT_WARNING_IN(flt[2]), .VIN_OV_IN(flt[3]), .VIN_UV_IN(flt[4]), .UNIT_OFF_LOW_VIN_IN(flt[5]),
    .OVERTEMPERATURE_FAULT_IN(flt[6]), .OVERTEMPERATURE_WARNING_IN(flt[7]), .VIN_MEAS, .VOUT_MEAS, .IOUT_MEAS,
    .TEMP_MEAS, .VOUT_GAIN, .VOUT_OFFSET, .VIN_GAIN,
    .WRITE_PROTECT, .SUMMARY_LOW);

  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge CORE_CLK);
    #1 NRST = 1'b1;
    for (int i = 0; i < 29; i++) begin
      host.xfer(rows[i][40], rows[i][39:32], rows[i][31:16], got);
      chk(got, rows[i][15:0]);
    end
    chk(VIN_GAIN, 16'h2100);
    chk(VOUT_OFFSET, 16'ha123);
    // ============================================================
    // Fault flags set, then cleared by writing ones
    @(posedge CORE_CLK);
    #1 flt = 8'hff;
    repeat (6) @(posedge CORE_CLK);
    #1 flt = 8'h00;
    repeat (4) @(posedge CORE_CLK);
    #1 chk({8'h00, SUMMARY_LOW}, 16'h007e);
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, scode[i], 16'h0000, got);
      chk(got, sexp[i]);
      host.xfer(1'b1, scode[i], 16'h00ff, got);
      host.xfer(1'b0, scode[i], 16'h0000, got);
      chk(got, 16'h0000);
    end
    host.xfer(1'b1, 8'h7e, 16'h00ff, got);
    host.pec_fail();
    host.xfer(1'b0, 8'h7e, 16'h0000, got);
    chk(got, 16'h0020);
    // ============================================================
    // Reset in mid-run restores defaults
    @(posedge CORE_CLK);
    #1 NRST = 1'b0;
    #1 chk({WRITE_PROTECT, VOUT_GAIN[14:0]}, 16'ha000);
    repeat (3) @(posedge CORE_CLK);
    #1 NRST = 1'b1;
    host.xfer(1'b0, 8'hd1, 16'h0000, got);
    chk(got, 16'h2000);
    end_sim();
  end
endmodule // pmbus_status_and_calibration_regs_bench

bind pmbus_status_cal_bank pmbus_status_cal_bank_props props (.CORE_CLK, .NRST, .CMD_CODE, .WR_STB, .WR_DATA,
  .RD_STB, .RD_DATA, .RD_VALID, .WR_DONE, .WR_REJECT, .VIN_MEAS, .VOUT_MEAS, .VOUT_GAIN, .WRITE_PROTECT);
`default_nettype wire

//--- test/pmbus_status_cal_bank_props.sv
// Purpose: Concurrent checks on the status and calibration bank ports
// Assumes: One clock domain, NRST asynchronous active low
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_cal_bank_props (
  input wire CORE_CLK,
  input wire NRST,
  input wire [7:0] CMD_CODE,
  input wire WR_STB,
  input wire [15:0] WR_DATA,
  input wire RD_STB,
  input wire [15:0] RD_DATA,
  input wire RD_VALID,
  input wire WR_DONE,
  input wire WR_REJECT,
  input wire [15:0] VIN_MEAS,
  input wire [15:0] VOUT_MEAS,
  input wire [15:0] VOUT_GAIN,
  input wire WRITE_PROTECT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  read_answer_a: assert property (RD_VALID == $past(RD_STB))
    else $error("read answer not one cycle after strobe");
  write_answer_a: assert property (WR_STB |=> WR_DONE != WR_REJECT)
    else $error("write answer missing or doubled");
  vin_read_a: assert property (RD_STB && CMD_CODE == 8'h88 |=> RD_DATA == $past(VIN_MEAS))
    else $error("input voltage reading wrong");
  vout_read_a: assert property (RD_STB && CMD_CODE == 8'h8b |=> RD_DATA == $past(VOUT_MEAS))
    else $error("output voltage reading wrong");
  id_layout_a: assert property (RD_STB && CMD_CODE == 8'hd0 |=> RD_DATA[15:8] == 8'h00 && RD_DATA[7] && !RD_DATA[0])
    else $error("identity word layout wrong");
  protect_reset_a: assert property ($rose(NRST) |-> WRITE_PROTECT)
    else $error("write protect not set after reset");
  cal_lock_a: assert property (WR_STB && WRITE_PROTECT && CMD_CODE[7:2] == 6'h34 && CMD_CODE[1:0] != 2'b00
    |=> WR_REJECT)
    else $error("calibration write taken while protected");
  gain_range_a: assert property (WR_STB && CMD_CODE == 8'hd1 && (WR_DATA < 16'h1999 || WR_DATA > 16'h2666)
    |=> WR_REJECT ##1 VOUT_GAIN == $past(VOUT_GAIN, 2))
    else $error("out of range gain taken");
  offset_exp_a: assert property (WR_STB && CMD_CODE == 8'hd2 && WR_DATA[15:11] != 5'h14 |=> WR_REJECT)
    else $error("offset with wrong exponent taken");
  gain_take_a: assert property (WR_STB && CMD_CODE == 8'hd1 && !WRITE_PROTECT && WR_DATA >= 16'h1999
    && WR_DATA <= 16'h2666 |=> WR_DONE ##1 VOUT_GAIN == $past(WR_DATA, 2))
    else $error("valid gain not stored");
endmodule // pmbus_status_cal_bank_props
`default_nettype wire
